// File: hdl/drdp_pkg.sv
// ==========================================================
// Shared constants for the data RAM / DMA port
package drdp_pkg;

	// ==========================================================
	// Widths
	localparam int unsigned WORD_ADDR_W = 24;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned LANE_W = 8;
	localparam int unsigned BYTE_SEL_W = 2;

	// ==========================================================
	// Transfer direction and size codes
	localparam logic XFER_DIR_READ = 1'h0;
	localparam logic XFER_DIR_WRITE = 1'h1;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_RSVD = 2'h3;

	// ==========================================================
	// Lane enable patterns
	localparam logic [3:0] WE_NONE = 4'h0;
	localparam logic [3:0] WE_BYTE0 = 4'h1;
	localparam logic [3:0] WE_HALF_LO = 4'h3;
	localparam logic [3:0] WE_HALF_HI = 4'hc;
	localparam logic [3:0] WE_ALL = 4'hf;

	// ==========================================================
	// Reset values
	localparam logic RST_DUAL = 1'h0;
	localparam logic RST_ABSENT = 1'h1;
	localparam logic [31:0] RST_DATA = 32'h0;
	localparam logic [23:0] RST_ADDR = 24'h0;

	// ==========================================================
	// Stall handshake states
	typedef enum logic [1:0] {
		STALL_RUN = 2'b00,
		STALL_DRAIN = 2'b01,
		STALL_HELD = 2'b10
	} drdp_stall_t;

endpackage : drdp_pkg

// File: hdl/drdp_lane_decode.sv
`timescale 1ns/1ps
// ==========================================================
// DMA byte address to word address and lane enables
module drdp_lane_decode #(
	parameter int unsigned WORD_ADDR_W = drdp_pkg::WORD_ADDR_W
) (
	// Transfer request
	input wire logic [WORD_ADDR_W+1:0] byte_addr,
	input wire logic [1:0] size,
	input wire logic write_sel,
	// Decoded access
	output logic [WORD_ADDR_W-1:0] word_addr,
	output logic [3:0] byte_we,
	output logic size_ok
);

	// ==========================================================
	// Lane selection
	function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] lo);
		logic [3:0] r;
		r = drdp_pkg::WE_NONE;
		unique case (sz)
			drdp_pkg::SIZE_BYTE: r = drdp_pkg::WE_BYTE0 << lo;
			drdp_pkg::SIZE_HALF: r = lo[1] ? drdp_pkg::WE_HALF_HI : drdp_pkg::WE_HALF_LO;
			drdp_pkg::SIZE_WORD: r = drdp_pkg::WE_ALL;
			drdp_pkg::SIZE_RSVD: r = drdp_pkg::WE_NONE;
		endcase
		return r;
	endfunction : lanes

	// Reads always take the whole word, so size only matters for writes
	assign word_addr = byte_addr[WORD_ADDR_W+1:drdp_pkg::BYTE_SEL_W];
	assign byte_we = (write_sel == drdp_pkg::XFER_DIR_WRITE) ?
		lanes(size, byte_addr[1:0]) : drdp_pkg::WE_NONE;
	assign size_ok = (write_sel == drdp_pkg::XFER_DIR_READ) ||
		(size != drdp_pkg::SIZE_RSVD);

endmodule : drdp_lane_decode

// File: hdl/drdp_port.sv
`timescale 1ns/1ps
// ==========================================================
module drdp_port #(
	parameter int unsigned WORD_ADDR_W = drdp_pkg::WORD_ADDR_W,
	parameter int unsigned DATA_W = drdp_pkg::DATA_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Configuration straps
	input wire logic dual_port_ram,
	input wire logic data_mem_absent,
	// Core data access
	input wire logic core_req,
	input wire logic [WORD_ADDR_W-1:0] core_word_addr,
	input wire logic [DATA_W-1:0] core_wr_data,
	input wire logic [DATA_W/8-1:0] core_byte_we,
	output logic core_stall,
	output logic [DATA_W-1:0] core_rd_data,
	output logic core_rd_valid,
	// DMA master
	input wire logic xfer_req_n,
	input wire logic xfer_write_sel,
	input wire logic [1:0] xfer_size,
	input wire logic [WORD_ADDR_W+1:0] xfer_byte_addr,
	input wire logic [DATA_W-1:0] xfer_wr_data,
	input wire logic xfer_port_en,
	input wire logic xfer_stall_req,
	output logic xfer_stall_ack,
	output logic [DATA_W-1:0] xfer_rd_data,
	output logic xfer_rd_valid,
	// Primary data RAM port
	output logic [WORD_ADDR_W-1:0] dram_word_addr,
	output logic dram_chip_en,
	input wire logic [DATA_W-1:0] dram_rd_bus,
	output logic [DATA_W-1:0] dram_wr_bus,
	output logic [DATA_W/8-1:0] dram_byte_we,
	// Second data RAM port, DMA only
	output logic [WORD_ADDR_W-1:0] port2_word_addr,
	output logic port2_chip_en,
	input wire logic [DATA_W-1:0] port2_rd_bus,
	output logic [DATA_W-1:0] port2_wr_bus,
	output logic [DATA_W/8-1:0] port2_byte_we
);

	localparam int unsigned LANES = DATA_W / drdp_pkg::LANE_W;
	localparam logic [LANES-1:0] NO_WE = '0;

	// ==========================================================
	// Strap synchronisers
	// Straps are meant to be static; the two stages only keep
	// metastability out of the decode logic.
	logic dual_meta;
	logic dual_sync;
	logic absent_meta;
	logic absent_sync;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dual_meta <= drdp_pkg::RST_DUAL;
			dual_sync <= drdp_pkg::RST_DUAL;
		end else begin
			dual_meta <= dual_port_ram;
			dual_sync <= dual_meta;
		end
	end

	// Absent resets high so nothing reaches the RAM before the strap settles
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			absent_meta <= drdp_pkg::RST_ABSENT;
			absent_sync <= drdp_pkg::RST_ABSENT;
		end else begin
			absent_meta <= data_mem_absent;
			absent_sync <= absent_meta;
		end
	end

	// ==========================================================
	// DMA request decode
	logic [WORD_ADDR_W-1:0] dec_word_addr;
	logic [LANES-1:0] dec_byte_we;
	logic dec_size_ok;

	drdp_lane_decode #(
		.WORD_ADDR_W(WORD_ADDR_W)
	) u_lane_decode (
		.byte_addr(xfer_byte_addr),
		.size(xfer_size),
		.write_sel(xfer_write_sel),
		.word_addr(dec_word_addr),
		.byte_we(dec_byte_we),
		.size_ok(dec_size_ok)
	);

	// ==========================================================
	// Access qualification
	wire decode_on = !absent_sync;
	wire single_mode = !dual_sync;
	// Request is active low and only counts with the port enabled
	wire dma_req = !xfer_req_n && xfer_port_en;
	// Single-port transfers wait until the core is known to be halted
	wire dma_go = dma_req && dec_size_ok && decode_on &&
		(dual_sync || xfer_stall_ack);
	wire dma_is_read = xfer_write_sel == drdp_pkg::XFER_DIR_READ;
	wire core_take = core_req && !core_stall;
	wire core_ram = core_take && decode_on;
	wire core_is_read = core_byte_we == NO_WE;
	wire pri_dma = single_mode && dma_go;
	wire p2_dma = dual_sync && dma_go;
	// Dual-port parts ignore the stall request, so DMA never halts the core
	wire stall_wanted = single_mode && xfer_stall_req;
	wire core_rd_start = core_take && core_is_read;
	wire dma_rd_start = dma_go && dma_is_read;

	// ==========================================================
	// Primary port selection
	// DMA wins the mux; the halt handshake already keeps the core off.
	wire next_dram_chip_en = pri_dma || core_ram;
	wire [WORD_ADDR_W-1:0] next_dram_word_addr =
		pri_dma ? dec_word_addr : core_word_addr;
	wire [DATA_W-1:0] next_dram_wr_bus =
		pri_dma ? xfer_wr_data : core_wr_data;
	wire [LANES-1:0] next_dram_byte_we =
		pri_dma ? dec_byte_we : (core_ram ? core_byte_we : NO_WE);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dram_chip_en <= 1'b0;
			dram_word_addr <= drdp_pkg::RST_ADDR;
			dram_wr_bus <= drdp_pkg::RST_DATA;
			dram_byte_we <= NO_WE;
		end else begin
			dram_chip_en <= next_dram_chip_en;
			dram_byte_we <= next_dram_byte_we;
			// Address and data hold between accesses to keep RAM inputs quiet
			if (next_dram_chip_en) begin
				dram_word_addr <= next_dram_word_addr;
				dram_wr_bus <= next_dram_wr_bus;
			end
		end
	end

	// ==========================================================
	// Second port, DMA only
	// Only DMA reaches this port, so it needs no arbitration
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			port2_chip_en <= 1'b0;
			port2_word_addr <= drdp_pkg::RST_ADDR;
			port2_wr_bus <= drdp_pkg::RST_DATA;
			port2_byte_we <= NO_WE;
		end else begin
			port2_chip_en <= p2_dma;
			port2_byte_we <= p2_dma ? dec_byte_we : NO_WE;
			if (p2_dma) begin
				port2_word_addr <= dec_word_addr;
				port2_wr_bus <= xfer_wr_data;
			end
		end
	end

	// ==========================================================
	// Core halt handshake
	// DRAIN gives an accepted core access one cycle to reach the RAM
	// before ready is shown, so the two never meet on a shared port.
	drdp_pkg::drdp_stall_t state;
	drdp_pkg::drdp_stall_t next_state;

	always_comb begin
		next_state = state;
		unique case (state)
			drdp_pkg::STALL_RUN: begin
				if (stall_wanted) begin
					next_state = drdp_pkg::STALL_DRAIN;
				end
			end
			drdp_pkg::STALL_DRAIN: begin
				if (stall_wanted) begin
					next_state = drdp_pkg::STALL_HELD;
				end else begin
					next_state = drdp_pkg::STALL_RUN;
				end
			end
			drdp_pkg::STALL_HELD: begin
				if (!stall_wanted) begin
					next_state = drdp_pkg::STALL_RUN;
				end
			end
			default: next_state = drdp_pkg::STALL_RUN;
		endcase
	end

	// Outputs decoded from the next state so they move together with it
	wire next_core_stall = next_state != drdp_pkg::STALL_RUN;
	wire next_stall_ack = next_state == drdp_pkg::STALL_HELD;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= drdp_pkg::STALL_RUN;
			core_stall <= 1'b0;
			xfer_stall_ack <= 1'b0;
		end else begin
			state <= next_state;
			core_stall <= next_core_stall;
			xfer_stall_ack <= next_stall_ack;
		end
	end

	// ==========================================================
	// Read return tracking
	// Stage one lines up with the chip enable, stage two with the
	// cycle in which the RAM shows the word.
	logic core_rd_s1;
	logic core_rd_s2;
	logic core_hit_s1;
	logic core_hit_s2;
	logic dma_rd_s1;
	logic dma_rd_s2;
	logic dma_p2_s1;
	logic dma_p2_s2;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			core_rd_s1 <= 1'b0;
			core_rd_s2 <= 1'b0;
			core_hit_s1 <= 1'b0;
			core_hit_s2 <= 1'b0;
		end else begin
			core_rd_s1 <= core_rd_start;
			core_rd_s2 <= core_rd_s1;
			core_hit_s1 <= core_ram;
			core_hit_s2 <= core_hit_s1;
		end
	end

	// DMA side also tracks which port ran, so the right read bus is taken
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dma_rd_s1 <= 1'b0;
			dma_rd_s2 <= 1'b0;
			dma_p2_s1 <= 1'b0;
			dma_p2_s2 <= 1'b0;
		end else begin
			dma_rd_s1 <= dma_rd_start;
			dma_rd_s2 <= dma_rd_s1;
			dma_p2_s1 <= p2_dma;
			dma_p2_s2 <= dma_p2_s1;
		end
	end

	// ==========================================================
	// Read data capture
	// Core reads while the RAM is absent still complete, returning zero.
	wire [DATA_W-1:0] core_word = core_hit_s2 ? dram_rd_bus : drdp_pkg::RST_DATA;
	// An idle port shows stale data, so only the port that ran is read
	wire [DATA_W-1:0] dma_word = dma_p2_s2 ? port2_rd_bus : dram_rd_bus;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			core_rd_data <= drdp_pkg::RST_DATA;
			core_rd_valid <= 1'b0;
		end else begin
			core_rd_valid <= core_rd_s2;
			if (core_rd_s2) begin
				core_rd_data <= core_word;
			end
		end
	end

	// Held until the next DMA read replaces it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			xfer_rd_data <= drdp_pkg::RST_DATA;
			xfer_rd_valid <= 1'b0;
		end else begin
			xfer_rd_valid <= dma_rd_s2;
			if (dma_rd_s2) begin
				xfer_rd_data <= dma_word;
			end
		end
	end

endmodule : drdp_port

// File: verif/drdp_ram_model.sv
`timescale 1ns/1ps
// ==========================================================
// One data RAM port: word read back the cycle after chip enable
module drdp_ram_model (
	// Clock
	input wire logic clock,
	// RAM port
	input wire logic [23:0] word_addr,
	input wire logic chip_en,
	input wire logic [31:0] wr_bus,
	input wire logic [3:0] byte_we,
	output logic [31:0] rd_bus
);
	logic [31:0] mem [0:15];
	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 32'h1111_0000 + i;
		rd_bus = 32'h0;
	end
	// Bus inverts itself every cycle without a read, so stale data never holds still
	always @(posedge clock) begin
		if (chip_en && byte_we == 4'h0) rd_bus <= mem[word_addr[3:0]];
		else rd_bus <= ~rd_bus;
		for (int b = 0; b < 4; b++)
			if (chip_en && byte_we[b]) mem[word_addr[3:0]][8*b +: 8] <= wr_bus[8*b +: 8];
	end
endmodule : drdp_ram_model

// File: verif/drdp_port_checker.sv
`timescale 1ns/1ps
// ==========================================================
// Port timing and decode checks
module drdp_port_checker (
	// Clock, reset, straps
	input wire logic clock,
	input wire logic rstn,
	input wire logic dual_port_ram,
	input wire logic data_mem_absent,
	// Core side
	input wire logic core_req,
	input wire logic [23:0] core_word_addr,
	input wire logic [3:0] core_byte_we,
	input wire logic core_stall,
	// DMA side
	input wire logic xfer_req_n,
	input wire logic xfer_write_sel,
	input wire logic [1:0] xfer_size,
	input wire logic [25:0] xfer_byte_addr,
	input wire logic xfer_port_en,
	input wire logic xfer_stall_req,
	input wire logic xfer_stall_ack,
	input wire logic [31:0] xfer_rd_data,
	input wire logic xfer_rd_valid,
	// RAM ports
	input wire logic [23:0] dram_word_addr,
	input wire logic dram_chip_en,
	input wire logic [31:0] dram_rd_bus,
	input wire logic [3:0] dram_byte_we,
	input wire logic port2_chip_en,
	input wire logic [31:0] port2_rd_bus
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	wire logic take = !xfer_req_n && xfer_port_en && !data_mem_absent
		&& (dual_port_ram || xfer_stall_ack);
	wire logic [1:0] lane = xfer_byte_addr[1:0];
	wire logic [23:0] dword = xfer_byte_addr[25:2];
	sequence stall_up_s;
		!dual_port_ram && xfer_stall_req ##1 xfer_stall_req && core_stall;
	endsequence
	ack_needs_stall_a: assert property (xfer_stall_ack |-> core_stall)
		else $error("ack without core stall");
	ack_timing_a: assert property (stall_up_s |=> xfer_stall_ack)
		else $error("stall ack late");
	stall_release_a: assert property (core_stall && !xfer_stall_req |=> !core_stall)
		else $error("stall not released");
	dual_run_a: assert property (dual_port_ram && $past(dual_port_ram, 3) |-> !core_stall)
		else $error("core stalled in dual mode");
	core_access_a: assert property (core_req && !core_stall && !data_mem_absent |=>
		dram_chip_en && dram_word_addr == $past(core_word_addr)
		&& dram_byte_we == $past(core_byte_we)) else $error("core access lost");
	port_gate_a: assert property (!xfer_port_en && !core_req |=>
		!dram_chip_en && !port2_chip_en) else $error("disabled DMA reached RAM");
	absent_off_a: assert property (data_mem_absent && $past(data_mem_absent, 3) |->
		!dram_chip_en && !port2_chip_en) else $error("access with RAM absent");
	dma_read_a: assert property (take && !xfer_write_sel |-> ##3 xfer_rd_valid
		&& xfer_rd_data == (dual_port_ram ? $past(port2_rd_bus) : $past(dram_rd_bus)))
		else $error("DMA read data wrong");
	byte_lane_a: assert property (take && xfer_write_sel && xfer_size == 2'h0
		&& !dual_port_ram |=> dram_chip_en && dram_byte_we == 4'h1 << $past(lane)
		&& dram_word_addr == $past(dword)) else $error("byte lane decode wrong");
	rsvd_drop_a: assert property (take && xfer_write_sel && xfer_size == 2'h3
		&& !core_req |=> !dram_chip_en && !port2_chip_en) else $error("reserved size taken");
endmodule : drdp_port_checker

bind drdp_port drdp_port_checker u_chk (.clock, .rstn, .dual_port_ram, .data_mem_absent,
	.core_req, .core_word_addr, .core_byte_we, .core_stall, .xfer_req_n, .xfer_write_sel,
	.xfer_size, .xfer_byte_addr, .xfer_port_en, .xfer_stall_req, .xfer_stall_ack,
	.xfer_rd_data, .xfer_rd_valid, .dram_word_addr, .dram_chip_en, .dram_rd_bus,
	.dram_byte_we, .port2_chip_en, .port2_rd_bus);

// File: verif/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the data RAM / DMA port
module tb_top;
	logic clock = 1'h0, rstn = 1'h0, dual_port_ram = 1'h0, data_mem_absent = 1'h0;
	logic core_req = 1'h0, xfer_req_n = 1'h1, xfer_write_sel = 1'h0;
	logic xfer_port_en = 1'h1, xfer_stall_req = 1'h0;
	logic [1:0] xfer_size = 2'h0;
	logic [3:0] core_byte_we = 4'h0;
	logic [23:0] core_word_addr = 24'h0;
	logic [25:0] xfer_byte_addr = 26'h0;
	logic [31:0] core_wr_data = 32'h0, xfer_wr_data = 32'h0;
	logic core_stall, core_rd_valid, xfer_stall_ack, xfer_rd_valid, dram_chip_en, port2_chip_en;
	logic [3:0] dram_byte_we, port2_byte_we;
	logic [23:0] dram_word_addr, port2_word_addr;
	logic [31:0] core_rd_data, xfer_rd_data, dram_rd_bus, dram_wr_bus, port2_rd_bus, port2_wr_bus;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	always #2 clock = ~clock;
	drdp_port u_dut (.clock, .rstn, .dual_port_ram, .data_mem_absent, .core_req,
		.core_word_addr, .core_wr_data, .core_byte_we, .core_stall, .core_rd_data,
		.core_rd_valid, .xfer_req_n, .xfer_write_sel, .xfer_size, .xfer_byte_addr,
		.xfer_wr_data, .xfer_port_en, .xfer_stall_req, .xfer_stall_ack, .xfer_rd_data,
		.xfer_rd_valid, .dram_word_addr, .dram_chip_en, .dram_rd_bus, .dram_wr_bus,
		.dram_byte_we, .port2_word_addr, .port2_chip_en, .port2_rd_bus, .port2_wr_bus,
		.port2_byte_we);
	drdp_ram_model u_ram1 (.clock(clock), .word_addr(dram_word_addr), .chip_en(dram_chip_en),
		.wr_bus(dram_wr_bus), .byte_we(dram_byte_we), .rd_bus(dram_rd_bus));
	drdp_ram_model u_ram2 (.clock(clock), .word_addr(port2_word_addr), .chip_en(port2_chip_en),
		.wr_bus(port2_wr_bus), .byte_we(port2_byte_we), .rd_bus(port2_rd_bus));
	task finish_test();
		if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	// Hang guard: the whole run needs well under a hundred cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 1000) begin
			mismatches++;
			finish_test();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task core_op(input logic [23:0] a, input logic [3:0] we, input logic [31:0] d,
		input logic en, input logic [31:0] exp);
		core_req = 1'h1;
		core_word_addr = a;
		core_byte_we = we;
		core_wr_data = d;
		step(1);
		core_req = 1'h0;
		chk(dram_chip_en, en);
		if (en) chk(dram_word_addr, a);
		if (en) chk(dram_byte_we, we);
		if (en && we != 4'h0) chk(dram_wr_bus, d);
		step(2);
		chk(core_rd_valid, we == 4'h0);
		if (we == 4'h0) chk(core_rd_data, exp);
	endtask : core_op
	task dma_op(input logic w, input logic [1:0] sz, input logic [25:0] a,
		input logic [31:0] d, input logic [3:0] we, input logic [31:0] exp);
		logic on;
		on = !w || sz != 2'h3;
		xfer_req_n = 1'h0;
		xfer_write_sel = w;
		xfer_size = sz;
		xfer_byte_addr = a;
		xfer_wr_data = d;
		step(1);
		xfer_req_n = 1'h1;
		chk(dual_port_ram ? port2_chip_en : dram_chip_en, on);
		if (on) chk(dual_port_ram ? port2_byte_we : dram_byte_we, we);
		if (on) chk(dual_port_ram ? port2_word_addr : dram_word_addr, a[25:2]);
		if (on && w) chk(dual_port_ram ? port2_wr_bus : dram_wr_bus, d);
		step(2);
		chk(xfer_rd_valid, !w);
		if (!w) chk(xfer_rd_data, exp);
	endtask : dma_op
	task t_core();
		core_op(24'h5, 4'hf, 32'hcafe_0123, 1'h1, 32'h0);
		core_op(24'h5, 4'h1, 32'h0000_00aa, 1'h1, 32'h0);
		core_op(24'h5, 4'h0, 32'h0, 1'h1, 32'hcafe_01aa);
	endtask : t_core
	task t_single();
		xfer_stall_req = 1'h1;
		for (int i = 0; i < 4 && xfer_stall_ack !== 1'h1; i++) step(1);
		chk(xfer_stall_ack, 1'h1);
		chk(core_stall, 1'h1);
		dma_op(1'h1, 2'h0, {24'h3, 2'h1}, 32'h0000_dd00, 4'h2, 32'h0);
		dma_op(1'h1, 2'h1, {24'h3, 2'h2}, 32'hbeef_0000, 4'hc, 32'h0);
		dma_op(1'h1, 2'h3, {24'h3, 2'h0}, 32'hffff_ffff, 4'h0, 32'h0);
		dma_op(1'h0, 2'h0, {24'h3, 2'h0}, 32'h0, 4'h0, 32'hbeef_dd03);
		xfer_stall_req = 1'h0;
		step(2);
		chk(core_stall, 1'h0);
	endtask : t_single
	task t_dual();
		dual_port_ram = 1'h1;
		step(4);
		fork
			core_op(24'h6, 4'h0, 32'h0, 1'h1, 32'h1111_0006);
			dma_op(1'h1, 2'h2, {24'h6, 2'h0}, 32'h600d_f00d, 4'hf, 32'h0);
		join
		chk(core_stall, 1'h0);
		dma_op(1'h0, 2'h2, {24'h6, 2'h0}, 32'h0, 4'h0, 32'h600d_f00d);
		xfer_port_en = 1'h0;
		xfer_req_n = 1'h0;
		step(1);
		xfer_req_n = 1'h1;
		chk(port2_chip_en, 1'h0);
		xfer_port_en = 1'h1;
		dual_port_ram = 1'h0;
		step(4);
	endtask : t_dual
	task t_absent();
		data_mem_absent = 1'h1;
		step(4);
		core_op(24'h5, 4'h0, 32'h0, 1'h0, 32'h0);
		data_mem_absent = 1'h0;
		step(4);
	endtask : t_absent
	initial begin
		step(8);
		rstn = 1'h1;
		step(4);
		t_core();
		t_single();
		t_dual();
		t_absent();
		finish_test();
	end
endmodule : tb_top
